// ==== logic/acc_pkg.sv ====
// Purpose: shared constants and types for the converter control block
// Assumes: 50 MHz system clock, AHB-Lite register access
// Notes: offsets and extra register layout are local choices
package acc_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TADDIV = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_CLR = 8'h0C;
   localparam logic [7:0] OFS_IEN = 8'h10;
   localparam logic [7:0] OFS_RUN = 8'h14;
   // ****************************************
   // control field positions
   // ****************************************
   localparam int B_ON = 15;
   localparam int B_IDLE = 13;
   localparam int B_DMA = 12;
   localparam int B_RES = 10;
   localparam int B_FORM = 8;
   localparam int B_TRIGGER_SOURCE_SELECT = 5;
   localparam int B_TRIGGER_SOURCE_GROUP = 4;
   localparam int B_SIM = 3;
   localparam int B_AUTO_SAMPLE_ENABLE = 2;
   localparam int B_SAMPLE_HOLD_CONTROL = 1;
   localparam int B_DONE = 0;
   localparam logic [15:0] CTRL_WMASK = 16'hB7FE;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [7:0] TADDIV_RST = 8'h03;
   // ****************************************
   // status bits: done, stabilised, sample start
   // ****************************************
   localparam int ST_DONE = 0;
   localparam int ST_STABLE = 1;
   localparam int ST_SAMPLE_HOLD_CONTROL = 2;
   localparam int NUM_EV = 3;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_MHZ = 50;
   localparam int T_STAB_US = 20;
   localparam int STAB_CYC = T_STAB_US * CLK_MHZ;
   localparam int SAMPLE_HOLD_CONTROL_MIN_TAD = 2;
   localparam int SAMPLE_HOLD_CONTROL_OPA_TAD = 4;
   localparam int START_DLY_TAD = 2;
   localparam int CONV_TAD = 12;
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_STAB = 3'b001,
      ST_IDLE = 3'b010,
      ST_PRE = 3'b011,
      ST_SMP = 3'b100,
      ST_CNV = 3'b101
   } acc_state_t;
   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic sel;
   } acc_req_t;
endpackage

// ==== logic/acc_ctrl.sv ====
// Purpose: converter enable, sampling and conversion sequencing
// Assumes: AHB-Lite single word accesses, one clock domain
// Notes: converter clock period is two ticks from a programmable divider
// Notes on behaviour
// - results indeterminate for 20 us after converter switched on
// - idle-halt bit set stops converter while device is idle
// - ordinary input sampling lasts at least 2 converter periods
// - op amp input sampling lasts at least 4 converter periods
// - conversion starts 2 to 3 periods after sample trigger
// - sampling starts 2 to 3 periods after sample bit set
// - auto-sample restarts sampling half a period after conversion
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
module acc_ctrl #(
   parameter int STAB_CYCLES = acc_pkg::STAB_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   input wire logic dev_idle_i,
   input wire logic opamp_sel_i,
   input wire logic trig_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic conv_busy_o,
   output logic sampling_o,
   output logic result_valid_o,
   output logic irq_o
);
   import acc_pkg::*;

   initial begin
      if (STAB_CYCLES < 1) begin
         $error("STAB_CYCLES must be positive");
      end
   end

   // ****************************************
   // bus slave
   // ****************************************
   acc_req_t req_q;
   logic [15:0] ctrl_q;
   logic [7:0] taddiv_q;
   logic [NUM_EV-1:0] stat_q;
   logic [NUM_EV-1:0] ien_q;
   logic [31:0] rdata_d;
   logic trig_s1_q, trig_s2_q, trig_s3_q;

   wire addr_ph = hsel_i & htrans_i[1] & hready_i;
   wire wr_ctrl = req_q.sel & req_q.write & (req_q.addr == OFS_CTRL);
   wire wr_div = req_q.sel & req_q.write & (req_q.addr == OFS_TADDIV);
   wire wr_clr = req_q.sel & req_q.write & (req_q.addr == OFS_CLR);
   wire wr_ien = req_q.sel & req_q.write & (req_q.addr == OFS_IEN);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_q <= '0;
      end else if (hready_i) begin
         req_q <= '{addr: haddr_i[7:0], write: hwrite_i, sel: addr_ph};
      end
   end

   // ****************************************
   // converter clock tick and sequencer
   // ****************************************
   acc_state_t st_q, st_d;
   logic [7:0] div_q;
   logic [4:0] tad_q;
   logic trig_lvl_q;
   logic trig_pend_q;
   logic [2:0] trig_cnt_q;
   logic [$clog2(STAB_CYCLES+1)-1:0] stab_q;
   wire halt = ctrl_q[B_IDLE] & dev_idle_i;
   wire on = ctrl_q[B_ON];
   // one tick per half period, so the 0.5 period restart can be counted
   wire tick = (div_q == taddiv_q) & on & ~halt;
   wire trig_rise = trig_s2_q & trig_s3_q & ~trig_lvl_q;
   wire [4:0] smp_len = opamp_sel_i ? 5'(2 * SAMPLE_HOLD_CONTROL_OPA_TAD)
                                    : 5'(2 * SAMPLE_HOLD_CONTROL_MIN_TAD);
   // trigger pulse is held, the fifth half tick lands 2 to 3 periods on
   wire trig_end = trig_pend_q
                   & (trig_cnt_q >= 3'(2 * START_DLY_TAD));
   wire smp_end = (st_q == ST_SMP) & tick & (tad_q + 5'h01 >= smp_len)
                  & (ctrl_q[B_AUTO_SAMPLE_ENABLE] | trig_end | ~ctrl_q[B_SAMPLE_HOLD_CONTROL]);
   wire pre_end = (st_q == ST_PRE) & tick
                  & (tad_q == 5'(2 * START_DLY_TAD - 1));
   wire cnv_end = (st_q == ST_CNV) & tick
                  & (tad_q == 5'(2 * CONV_TAD - 1));
   wire stab_done = (stab_q == '0);

   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_OFF: if (on) st_d = ST_STAB;
         ST_STAB: if (stab_done) st_d = ST_IDLE;
         ST_IDLE: if (tick) begin
            // auto restart skips the start delay
            if (ctrl_q[B_AUTO_SAMPLE_ENABLE]) st_d = ST_SMP;
            else if (ctrl_q[B_SAMPLE_HOLD_CONTROL]) st_d = ST_PRE;
         end
         ST_PRE: if (pre_end) st_d = ST_SMP;
         ST_SMP: if (smp_end) st_d = ST_CNV;
         ST_CNV: if (cnv_end) st_d = ST_IDLE;
         default: st_d = ST_OFF;
      endcase
      if (!on) st_d = ST_OFF;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         trig_s1_q <= 1'b0;
         trig_s2_q <= 1'b0;
         trig_s3_q <= 1'b0;
         trig_lvl_q <= 1'b0;
      end else begin
         trig_s1_q <= trig_i;
         trig_s2_q <= trig_s1_q;
         trig_s3_q <= trig_s2_q;
         if (trig_s2_q == trig_s3_q) begin
            trig_lvl_q <= trig_s3_q;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_q <= 8'h00;
      end else if (halt || !on) begin
         div_q <= 8'h00;
      end else if (div_q == taddiv_q) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= ST_OFF;
         tad_q <= 5'h00;
         stab_q <= '0;
         trig_pend_q <= 1'b0;
         trig_cnt_q <= 3'h0;
      end else if (!halt) begin
         if (st_q != ST_SMP || st_d != st_q) begin
            trig_pend_q <= 1'b0;
            trig_cnt_q <= 3'h0;
         end else if (trig_rise && !trig_pend_q) begin
            trig_pend_q <= 1'b1;
            trig_cnt_q <= 3'h0;
         end else if (trig_pend_q && tick && trig_cnt_q != 3'h7) begin
            trig_cnt_q <= trig_cnt_q + 3'h1;
         end
         if (st_q == ST_OFF) begin
            stab_q <= ($bits(stab_q))'(STAB_CYCLES - 1);
         end else if (!stab_done) begin
            stab_q <= stab_q - 1'b1;
         end
         st_q <= st_d;
         if (st_d != st_q) begin
            tad_q <= 5'h00;
         end else if (tick) begin
            tad_q <= tad_q + 5'h01;
         end
      end
   end

   // ****************************************
   // registers
   // ****************************************
   logic [NUM_EV-1:0] ev;
   assign ev[ST_DONE] = cnv_end & ~halt;
   assign ev[ST_STABLE] = (st_q == ST_STAB) & stab_done & ~halt;
   assign ev[ST_SAMPLE_HOLD_CONTROL] = (st_d == ST_SMP) & (st_q != ST_SMP) & ~halt;
   // read data is fetched in the address phase so it stands in data phase
   wire [7:0] rd_addr = haddr_i[7:0];
   wire [15:0] wctrl = (hwdata_i[15:0] & CTRL_WMASK)
                       | (ctrl_q & ~CTRL_WMASK);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_q <= CTRL_RST;
         taddiv_q <= TADDIV_RST;
         ien_q <= '0;
         stat_q <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= wctrl;
            // done bit is clear-only from software
            if (!hwdata_i[B_DONE]) begin
               ctrl_q[B_DONE] <= 1'b0;
            end
         end
         if (smp_end) begin
            ctrl_q[B_SAMPLE_HOLD_CONTROL] <= ctrl_q[B_AUTO_SAMPLE_ENABLE];
         end
         if (ev[ST_DONE]) begin
            ctrl_q[B_DONE] <= 1'b1;
         end
         if (wr_div) begin
            taddiv_q <= hwdata_i[7:0];
         end
         if (wr_ien) begin
            ien_q <= hwdata_i[NUM_EV-1:0];
         end
         // set wins over clear
         stat_q <= (stat_q & ~({NUM_EV{wr_clr}} & hwdata_i[NUM_EV-1:0]))
                   | ev;
      end
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (rd_addr == OFS_CTRL) begin
         rdata_d = {16'h0000, ctrl_q};
      end else if (rd_addr == OFS_TADDIV) begin
         rdata_d = {24'h000000, taddiv_q};
      end else if (rd_addr == OFS_STAT) begin
         rdata_d = {29'h0, stat_q};
      end else if (rd_addr == OFS_IEN) begin
         rdata_d = {29'h0, ien_q};
      end else if (rd_addr == OFS_RUN) begin
         rdata_d = {29'h0, st_q};
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hrdata_o <= 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         conv_busy_o <= 1'b0;
         sampling_o <= 1'b0;
         result_valid_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         hrdata_o <= (addr_ph && !hwrite_i) ? rdata_d : hrdata_o;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         conv_busy_o <= (st_d == ST_CNV);
         sampling_o <= (st_d == ST_SMP);
         // indeterminate results masked until stable
         result_valid_o <= (st_d != ST_OFF) & (st_d != ST_STAB);
         irq_o <= |(stat_q & ien_q);
      end
   end
endmodule

// ==== test/acc_ctrl_properties.sv ====
// Purpose: port checks for converter control
// Assumes: divider at reset, one period is 8 clocks
// Notes: counters saturate at 255
`timescale 1ns/100ps
module acc_ctrl_properties (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic trig_i,
   input wire logic opamp_sel_i,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic conv_busy_o,
   input wire logic sampling_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // ****************************************
   // phase length counters
   // ****************************************
   logic [7:0] smp_q;
   logic [7:0] cnv_q;
   logic [7:0] smp_d;
   logic [7:0] cnv_d;
   assign smp_d = !sampling_o ? 8'h00 : smp_q + {7'h00, smp_q != 8'hFF};
   assign cnv_d = !conv_busy_o ? 8'h00 : cnv_q + {7'h00, cnv_q != 8'hFF};
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         smp_q <= 8'h00;
         cnv_q <= 8'h00;
      end else begin
         smp_q <= smp_d;
         cnv_q <= cnv_d;
      end
   end
   sequence s_smp_end;
      $fell(sampling_o);
   endsequence
   property p_sample_hold_control_min;
      s_smp_end |-> smp_q >= 8'h10;
   endproperty
   property p_sample_hold_control_opa;
      s_smp_end ##0 opamp_sel_i |-> smp_q >= 8'h20;
   endproperty
   property p_conv_len;
      $fell(conv_busy_o) |-> cnv_q >= 8'h60;
   endproperty
   property p_busy_hold;
      $rose(conv_busy_o) |-> conv_busy_o [*8];
   endproperty
   property p_conv_follow;
      s_smp_end |-> ##[0:2] conv_busy_o;
   endproperty
   property p_excl;
      !(sampling_o && conv_busy_o);
   endproperty
   property p_trig;
      $rose(trig_i) && sampling_o |-> ##[3:40] conv_busy_o;
   endproperty
   property p_bus;
      hreadyout_o && !hresp_o;
   endproperty
   a_sample_hold_control_min: assert property (p_sample_hold_control_min) else $error("short sample");
   a_sample_hold_control_opa: assert property (p_sample_hold_control_opa) else $error("short opa");
   a_conv_len: assert property (p_conv_len) else $error("short conv");
   a_busy_hold: assert property (p_busy_hold) else $error("busy drop");
   a_conv_follow: assert property (p_conv_follow) else $error("no conv");
   a_excl: assert property (p_excl) else $error("overlap");
   a_trig: assert property (p_trig) else $error("late conv");
   a_bus: assert property (p_bus) else $error("bus answer");
endmodule
bind acc_ctrl acc_ctrl_properties i_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .trig_i(trig_i), .opamp_sel_i(opamp_sel_i), .hreadyout_o(hreadyout_o),
   .hresp_o(hresp_o), .conv_busy_o(conv_busy_o), .sampling_o(sampling_o));

// ==== test/test_adc_sample_convert_control.sv ====
// Purpose: self-checking bench for acc_ctrl
// Assumes: zero wait state bus, short stabilisation
// Notes: divider left at reset so the checker timing holds
`timescale 1ns/100ps
module test_adc_sample_convert_control;
   import acc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic hsel_i = 1'b0;
   logic [31:0] haddr_i = 32'h0;
   logic [1:0] htrans_i = 2'h0;
   logic hwrite_i = 1'b0;
   logic [2:0] hsize_i = 3'h2;
   logic [31:0] hwdata_i = 32'h0;
   logic dev_idle_i = 1'b0;
   logic opamp_sel_i = 1'b0;
   logic trig_i = 1'b0;
   logic [31:0] hrdata_o;
   logic hreadyout_o, hresp_o, conv_busy_o, sampling_o, result_valid_o, irq_o;
   int mismatches = 0;
   int checks = 0;
   int seed = 64;
   int cyc = 0;
   int n;
   logic [31:0] r;
   logic obs_q[$];
   logic exp_q[$];
   acc_ctrl #(.STAB_CYCLES(10)) i_acc_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
      .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
      .hready_i(hreadyout_o), .dev_idle_i(dev_idle_i),
      .opamp_sel_i(opamp_sel_i), .trig_i(trig_i), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .conv_busy_o(conv_busy_o), .sampling_o(sampling_o),
      .result_valid_o(result_valid_o), .irq_o(irq_o));
   initial forever #10 clk_i = ~clk_i;
   // ****************************************
   // checking and bus tasks
   // ****************************************
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic note(input logic got, input logic exp);
      obs_q.push_back(got);
      exp_q.push_back(exp);
   endtask
   always @(negedge clk_i)
      while (exp_q.size() > 0) begin
         checks++;
         if (obs_q.pop_front() !== exp_q.pop_front()) begin
            mismatches++;
            $display("BAD %0t output differs", $time);
         end
      end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 4000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= {24'h0, a};
      hwrite_i <= w;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      r = hrdata_o;
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: return sampling_o;
         1: return conv_busy_o;
         2: return result_valid_o;
         default: return irq_o;
      endcase
   endfunction
   task automatic wsig(input int s, input logic v);
      n = 0;
      while (sig(s) !== v && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      note(sig(s), v);
   endtask
   // sampling must have run its minimum before the trigger
   task automatic fire();
      repeat (40) @(posedge clk_i);
      trig_i <= 1'b1;
      wsig(1, 1'b1);
      trig_i <= 1'b0;
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      bus(1'b1, OFS_IEN, 32'h2);
      bus(1'b1, OFS_CTRL, 32'h8000);
      repeat (3) @(posedge clk_i);
      note(result_valid_o, 1'b0);
      wsig(2, 1'b1);
      note(n < 12, 1'b1);
      wsig(3, 1'b1);
      bus(1'b1, 8'h3C, $random(seed));
      bus(1'b0, OFS_CTRL, 32'h0);
      note(r[15:0] === 16'h8000, 1'b1);
      bus(1'b1, OFS_CLR, 32'h7);
      bus(1'b1, OFS_IEN, 32'h1);
      repeat (2) @(posedge clk_i);
      note(irq_o, 1'b0);
      $display("test enable done");
      opamp_sel_i <= 1'($random(seed));
      bus(1'b1, OFS_CTRL, 32'h8002);
      wsig(0, 1'b1);
      note(n >= 14 && n <= 26, 1'b1);
      fire();
      note(n >= 16 && n <= 30, 1'b1);
      wsig(1, 1'b0);
      note(n >= 92 && n <= 98, 1'b1);
      wsig(3, 1'b1);
      bus(1'b0, OFS_CTRL, 32'h0);
      note(r[1:0] === 2'b01, 1'b1);
      $display("test manual done");
      bus(1'b1, OFS_CLR, 32'h7);
      dev_idle_i <= 1'b1;
      bus(1'b1, OFS_CTRL, 32'hA004);
      repeat (60) @(posedge clk_i);
      note(sampling_o | conv_busy_o, 1'b0);
      dev_idle_i <= 1'b0;
      wsig(0, 1'b1);
      fire();
      wsig(1, 1'b0);
      wsig(0, 1'b1);
      note(n <= 8, 1'b1);
      bus(1'b1, OFS_CTRL, 32'h8005);
      dev_idle_i <= 1'b1;
      fire();
      $display("test auto done");
      @(posedge clk_i);
      report_and_stop();
   end
endmodule
